// ===== rtl/iopta_core.sv
/*
 * Signed integer outer-product unit: one tile element per cycle, four
 * products per element, result added into or taken from a whole tile.
 * Assumes the pipeline holds the issue inputs valid in the issue cycle
 * only, and takes the result tile on the done pulse.
 */
`timescale 1ns/1ps

module iopta_core #(
    parameter int VL           = iopta_pkg::VL_DEFAULT,
    parameter bit HALF_SUPPORT = iopta_pkg::HALF_SUPPORT_DEFAULT
) (
    // clock, reset, enable
    input  wire logic                         ref_clk_i,
    input  wire logic                         resetn_i,
    input  wire logic                         ce_i,
    // issue
    input  wire logic                         issue_i,
    input  wire iopta_pkg::iopta_req_type     req_i,
    input  wire logic [VL-1:0]                first_source_vector_i,
    input  wire logic [VL-1:0]                second_source_vector_i,
    input  wire logic [VL-1:0]                predicate_file_i,
    input  wire logic [VL*VL/32-1:0]          tile_i,
    // completion
    output logic                              busy_o,
    output logic                              done_o,
    output logic                              undefined_o,
    output logic [VL*VL/32-1:0]               result_tile_o,
    output logic [iopta_pkg::TILE_SEL_W-1:0]  result_tile_select_o,
    output logic                              halfword_to_doubleword_support_o
);
    import iopta_pkg::*;

    localparam int PL       = VL / 8;
    localparam int DIM_N    = VL / NARROW_ACC_W;
    localparam int DIM_W    = VL / WIDE_ACC_W;
    localparam int ELEMS_N  = DIM_N * DIM_N;
    localparam int ELEMS_W  = DIM_W * DIM_W;
    localparam int TW       = VL * VL / 32;
    localparam int CNT_W    = $clog2(ELEMS_N + 1);
    localparam logic [CNT_W-1:0] LAST_N = CNT_W'(ELEMS_N - 1);
    localparam logic [CNT_W-1:0] LAST_W = CNT_W'(ELEMS_W - 1);

    iopta_state_type       state;
    iopta_req_type         req;
    iopta_dec_type         dec;
    logic [VL-1:0]         op_a;
    logic [VL-1:0]         op_b;
    logic [PL-1:0]         mask_a;
    logic [PL-1:0]         mask_b;
    logic [TW-1:0]         acc_tile;
    logic [CNT_W-1:0]      elem_idx;
    logic [CNT_W-1:0]      elem_last;
    logic                  start;
    logic                  refuse;
    logic                  accept;
    logic                  last_elem;
    logic signed [PROD_W-1:0] dot;
    logic [WIDE_ACC_W-1:0] old_elem;
    logic [WIDE_ACC_W-1:0] next_elem;
    int                    row;
    int                    col;

    // decode of the instruction kind
    function automatic iopta_dec_type decode(input iopta_kind_type kind);
        iopta_dec_type d;
        d.negate_product_select          = (kind == OP_SUBTRACT);
        d.first_operand_unsigned_select  = 1'b0;
        d.second_operand_unsigned_select = 1'b0;
        return d;
    endfunction

    // one predicate out of the lower eight
    function automatic logic [PL-1:0] pick_pred(
        input logic [VL-1:0]          file,
        input logic [PRED_SEL_W-1:0]  sel
    );
        return file[int'(sel)*PL +: PL];
    endfunction

    // one source element, widened, zero when inactive
    function automatic logic signed [PROD_W-1:0] src_elem(
        input logic [VL-1:0] vec,
        input logic [PL-1:0] mask,
        input int            idx,
        input logic          wide,
        input logic          uns
    );
        logic [WIDE_SRC_W-1:0] h;
        logic [NARROW_SRC_W-1:0] b;
        logic signed [PROD_W-1:0] v;
        h = '0;
        b = '0;
        if (wide) begin
            // halfword slice read only in the wide form, index stays in range
            h = vec[idx*WIDE_SRC_W +: WIDE_SRC_W];
            v = uns ? PROD_W'(h) : PROD_W'($signed(h));
            if (!mask[idx*WIDE_PRED_STRIDE]) begin
                v = '0;
            end
        end else begin
            b = vec[idx*NARROW_SRC_W +: NARROW_SRC_W];
            v = uns ? PROD_W'(b) : PROD_W'($signed(b));
            if (!mask[idx*NARROW_PRED_STRIDE]) begin
                v = '0;
            end
        end
        return v;
    endfunction

    // 4-way dot product of a row group and a column group
    function automatic logic signed [PROD_W-1:0] dot4(
        input logic [VL-1:0] a,
        input logic [VL-1:0] b,
        input logic [PL-1:0] ma,
        input logic [PL-1:0] mb,
        input int            r,
        input int            c,
        input logic          wide,
        input iopta_dec_type d
    );
        logic signed [PROD_W-1:0] acc;
        logic signed [PROD_W-1:0] prod;
        acc = '0;
        for (int k = 0; k < K_WAY; k++) begin
            // row elements consecutive in a, column elements in b
            prod = src_elem(a, ma, K_WAY*r + k, wide,
                            d.first_operand_unsigned_select)
                 * src_elem(b, mb, K_WAY*c + k, wide,
                            d.second_operand_unsigned_select);
            if (d.negate_product_select) begin
                prod = -prod;
            end
            acc = acc + prod;
        end
        return acc;
    endfunction

    // bit position of a tile element in either form
    function automatic int elem_lsb(
        input logic [CNT_W-1:0] idx,
        input logic             wide
    );
        return wide ? int'(idx) * WIDE_ACC_W
                    : int'(idx) * NARROW_ACC_W;
    endfunction

    // request handling
    assign start     = ce_i && issue_i && (state == ST_IDLE);
    assign refuse    = req_i.wide && !HALF_SUPPORT;
    assign accept    = start && !refuse;
    assign last_elem = (elem_idx == elem_last);

    // element arithmetic for the current index
    always_comb begin
        row = req.wide ? int'(elem_idx) / DIM_W : int'(elem_idx) / DIM_N;
        col = req.wide ? int'(elem_idx) % DIM_W : int'(elem_idx) % DIM_N;
        dot = dot4(op_a, op_b, mask_a, mask_b, row, col, req.wide, dec);
        if (req.wide) begin
            old_elem = acc_tile[elem_lsb(elem_idx, 1'b1) +: WIDE_ACC_W];
        end else begin
            old_elem = WIDE_ACC_W'(
                acc_tile[elem_lsb(elem_idx, 1'b0) +: NARROW_ACC_W]);
        end
        next_elem = old_elem + WIDE_ACC_W'(dot);
    end

    // sequencer: fixed count per form, no data or flag input steers it
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ST_IDLE;
        end else if (ce_i) begin
            unique case (state)
                ST_IDLE: begin
                    if (accept) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (last_elem) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // element counter; back to zero at the end so no index leaves the tile
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            elem_idx  <= '0;
            elem_last <= '0;
        end else if (ce_i) begin
            if (accept) begin
                elem_idx  <= '0;
                elem_last <= req_i.wide ? LAST_W : LAST_N;
            end else if (state == ST_RUN) begin
                elem_idx <= last_elem ? '0 : elem_idx + CNT_W'(1);
            end
        end
    end

    // request and decoded kind, taken at issue
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req <= '0;
            dec <= '0;
        end else if (accept) begin
            req <= req_i;
            dec <= decode(req_i.kind);
        end
    end

    // source vectors, taken at issue
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            op_a <= '0;
            op_b <= '0;
        end else if (accept) begin
            op_a <= first_source_vector_i;
            op_b <= second_source_vector_i;
        end
    end

    // one predicate per source, chosen independently
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask_a <= '0;
            mask_b <= '0;
        end else if (accept) begin
            mask_a <= pick_pred(predicate_file_i,
                                req_i.first_predicate_select);
            mask_b <= pick_pred(predicate_file_i,
                                req_i.second_predicate_select);
        end
    end

    // working tile, loaded at issue and updated one element a cycle
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_tile <= '0;
        end else if (ce_i) begin
            if (accept) begin
                acc_tile <= tile_i;
            end else if (state == ST_RUN) begin
                if (req.wide) begin
                    acc_tile[elem_lsb(elem_idx, 1'b1) +: WIDE_ACC_W]
                        <= next_elem;
                end else begin
                    acc_tile[elem_lsb(elem_idx, 1'b0) +: NARROW_ACC_W]
                        <= next_elem[NARROW_ACC_W-1:0];
                end
            end
        end
    end

    assign result_tile_o = acc_tile;

    // busy from the accepting edge to the last element
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_o <= 1'b0;
        end else if (ce_i) begin
            if (accept) begin
                busy_o <= 1'b1;
            end else if ((state == ST_RUN) && last_elem) begin
                busy_o <= 1'b0;
            end
        end
    end

    // one-cycle completion pulse, whole tile valid with it
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= (state == ST_RUN) && last_elem;
        end
    end

    // one-cycle refusal pulse for the absent wide form
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            undefined_o <= 1'b0;
        end else if (ce_i) begin
            undefined_o <= start && refuse;
        end
    end

    // destination tile, high bit dropped for the narrow form
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            result_tile_select_o <= '0;
        end else if (accept) begin
            result_tile_select_o <= req_i.destination_tile_select
                & (req_i.wide ? WIDE_TILE_MASK
                              : NARROW_TILE_MASK);
        end
    end

    // feature identification bit
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            halfword_to_doubleword_support_o <= 1'b0;
        end else begin
            halfword_to_doubleword_support_o <= HALF_SUPPORT;
        end
    end

endmodule

// ===== inc/iopta_pkg.sv
/*
 * Shared constants and types of the integer outer-product tile unit.
 * Assumes the pipeline hands over whole operands in one issue cycle.
 */
package iopta_pkg;

    // default vector length in bits, a multiple of 64
    localparam int VL_DEFAULT = 128;
    // halfword source, doubleword tile form fitted or not
    localparam bit HALF_SUPPORT_DEFAULT = 1'b1;

    localparam int NUM_PRED   = 8;
    localparam int PRED_SEL_W = 3;
    localparam int TILE_SEL_W = 3;
    localparam int K_WAY      = 4;

    localparam int NARROW_SRC_W = 8;
    localparam int WIDE_SRC_W   = 16;
    localparam int NARROW_ACC_W = 32;
    localparam int WIDE_ACC_W   = 64;
    localparam int PROD_W       = 64;

    // predicate bits per source element
    localparam int NARROW_PRED_STRIDE = 1;
    localparam int WIDE_PRED_STRIDE   = 2;

    // tile select masks: four narrow tiles, eight wide tiles
    localparam logic [TILE_SEL_W-1:0] NARROW_TILE_MASK = 3'h3;
    localparam logic [TILE_SEL_W-1:0] WIDE_TILE_MASK   = 3'h7;

    typedef enum logic {
        OP_ACCUMULATE,
        OP_SUBTRACT
    } iopta_kind_type;

    typedef struct packed {
        iopta_kind_type              kind;
        logic                        wide;
        logic [TILE_SEL_W-1:0]       destination_tile_select;
        logic [PRED_SEL_W-1:0]       first_predicate_select;
        logic [PRED_SEL_W-1:0]       second_predicate_select;
    } iopta_req_type;

    typedef struct packed {
        logic negate_product_select;
        logic first_operand_unsigned_select;
        logic second_operand_unsigned_select;
    } iopta_dec_type;

    typedef enum {
        ST_IDLE,
        ST_RUN
    } iopta_state_type;

endpackage

// ===== tb/iopta_tile_model.sv
/*
 * Tile store beside the outer-product unit: supplies the current tile
 * and takes the result tile back on the done pulse.
 * Assumes the bench loads a fresh tile before each issue.
 */
`timescale 1ns/1ps

module iopta_tile_model #(
    parameter int TW = 512
) (
    // clock, reset
    input  wire logic          ref_clk_i,
    input  wire logic          resetn_i,
    // bench load, unit result
    input  wire logic          load_i,
    input  wire logic [TW-1:0] load_tile_i,
    input  wire logic          done_i,
    input  wire logic [TW-1:0] result_i,
    // current tile
    output logic      [TW-1:0] tile_o
);
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tile_o <= '0;
        end else if (load_i) begin
            tile_o <= load_tile_i;
        end else if (done_i) begin
            tile_o <= result_i;
        end
    end
endmodule

// ===== tb/iopta_checker.sv
/*
 * Port assertions of the outer-product unit.
 * Assumes ce_i stays high while an operation runs.
 */
`timescale 1ns/1ps

module iopta_checker #(
    parameter int VL           = 128,
    parameter bit HALF_SUPPORT = 1'b1
) (
    // clock, reset, issue
    input wire logic                        ref_clk_i,
    input wire logic                        resetn_i,
    input wire logic                        ce_i,
    input wire logic                        issue_i,
    input wire iopta_pkg::iopta_req_type    req_i,
    input wire logic [VL*VL/32-1:0]         tile_i,
    // completion
    input wire logic                        busy_o,
    input wire logic                        done_o,
    input wire logic                        undefined_o,
    input wire logic [VL*VL/32-1:0]         result_tile_o,
    input wire logic [2:0]                  result_tile_select_o,
    input wire logic                        halfword_to_doubleword_support_o
);
    import iopta_pkg::*;
    localparam int NN = (VL/32)*(VL/32)+1;
    localparam int NW = (VL/64)*(VL/64)+1;
    logic take;
    logic run_w;
    assign take = issue_i && ce_i && !busy_o;
    assign run_w = req_i.wide && HALF_SUPPORT;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_NARROW_LAT:
        assert property (take && !req_i.wide |-> ##NN done_o)
        else $error("narrow done at wrong cycle");
    AST_WIDE_LAT:
        assert property (take && run_w |-> ##NW done_o)
        else $error("wide done at wrong cycle");
    AST_BUSY_RUN:
        assert property (take && !req_i.wide |=> busy_o [*8])
        else $error("busy dropped during run");
    AST_UNDEF:
        assert property (take && req_i.wide && !HALF_SUPPORT
            |=> undefined_o && !busy_o)
        else $error("missing undefined pulse");
    AST_NO_UNDEF:
        assert property (take && !(req_i.wide && !HALF_SUPPORT)
            |=> !undefined_o)
        else $error("spurious undefined pulse");
    AST_SEL_NARROW:
        assert property (take && !req_i.wide |=> result_tile_select_o
            == {1'b0, $past(req_i.destination_tile_select[1:0])})
        else $error("narrow tile select wrong");
    AST_SEL_WIDE:
        assert property (take && run_w |=> result_tile_select_o
            == $past(req_i.destination_tile_select))
        else $error("wide tile select wrong");
    AST_FEATURE:
        assert property ($past(resetn_i) |->
            halfword_to_doubleword_support_o == HALF_SUPPORT)
        else $error("feature bit wrong");
    AST_TILE_LOAD:
        assert property (take && !(req_i.wide && !HALF_SUPPORT)
            |=> result_tile_o == $past(tile_i))
        else $error("run did not start from tile");
    AST_DONE_IDLE:
        assert property (done_o |-> !busy_o ##1 !done_o)
        else $error("done not a single idle pulse");
    cover property (take && run_w);
    cover property (undefined_o);
    cover property (issue_i && busy_o);
endmodule

bind iopta_core iopta_checker #(.VL(VL), .HALF_SUPPORT(HALF_SUPPORT)) chk_u (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .issue_i(issue_i), .req_i(req_i), .tile_i(tile_i), .busy_o(busy_o),
    .done_o(done_o), .undefined_o(undefined_o),
    .result_tile_o(result_tile_o),
    .result_tile_select_o(result_tile_select_o),
    .halfword_to_doubleword_support_o(halfword_to_doubleword_support_o));

// ===== tb/int_outer_product_tile_accumulate_tb.sv
/*
 * Self-checking bench of the outer-product unit, VL of 128.
 * Assumes the tile model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin \
    num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module int_outer_product_tile_accumulate_tb;
    import iopta_pkg::*;
    logic          ref_clk_i = 1'b0;
    logic          resetn_i  = 1'b0;
    logic          ce_i      = 1'b1;
    logic          issue_i   = 1'b0;
    logic          load      = 1'b0;
    iopta_req_type req_i     = '0;
    logic [127:0]  va = '0, vb = '0, pf;
    logic [511:0]  tile_i, res, lt = '0;
    logic          busy_o, done_o, undefined_o, feat, u2, b2, f2;
    logic [2:0]    sel;
    int            num_errors = 0, check_count = 0, cyc = 0;
    // predicate file P7..P0
    assign pf = 128'hFFFF_A5A5_0F0F_FFFF_3C3C_F0F0_FFFF_5A5A;
    always #20 ref_clk_i = ~ref_clk_i;

    iopta_core dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .ce_i(ce_i), .issue_i(issue_i), .req_i(req_i),
        .first_source_vector_i(va), .second_source_vector_i(vb),
        .predicate_file_i(pf), .tile_i(tile_i), .busy_o(busy_o),
        .done_o(done_o), .undefined_o(undefined_o), .result_tile_o(res),
        .result_tile_select_o(sel), .halfword_to_doubleword_support_o(feat));
    iopta_core #(.HALF_SUPPORT(1'b0)) dut2_u (.ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i), .ce_i(ce_i), .issue_i(issue_i), .req_i(req_i),
        .first_source_vector_i(va), .second_source_vector_i(vb),
        .predicate_file_i(pf), .tile_i(tile_i), .busy_o(b2), .done_o(),
        .undefined_o(u2), .result_tile_o(), .result_tile_select_o(),
        .halfword_to_doubleword_support_o(f2));
    iopta_tile_model tm_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .load_i(load), .load_tile_i(lt), .done_i(done_o), .result_i(res),
        .tile_o(tile_i));

    function automatic logic [511:0] ref_tile(input iopta_req_type q);
        logic [15:0]        m1, m2;
        logic signed [63:0] x, y, s;
        int                 d, i, j;
        m1 = pf[q.first_predicate_select*16 +: 16];
        m2 = pf[q.second_predicate_select*16 +: 16];
        d = q.wide ? 2 : 4;
        ref_tile = lt;
        for (int r = 0; r < d; r++) begin
            for (int c = 0; c < d; c++) begin
                s = q.wide ? lt[(r*d+c)*64 +: 64] : 64'(lt[(r*d+c)*32 +: 32]);
                for (int k = 0; k < 4; k++) begin
                    i = 4*r+k;
                    j = 4*c+k;
                    x = q.wide ? signed'(va[i*16 +: 16]) : signed'(va[i*8 +: 8]);
                    y = q.wide ? signed'(vb[j*16 +: 16]) : signed'(vb[j*8 +: 8]);
                    if (!(q.wide ? m1[2*i] && m2[2*j] : m1[i] && m2[j])) x = 0;
                    x = (q.kind == OP_SUBTRACT) ? -(x*y) : x*y;
                    s = s + x;
                end
                if (q.wide) ref_tile[(r*d+c)*64 +: 64] = s;
                else ref_tile[(r*d+c)*32 +: 32] = s[31:0];
            end
        end
    endfunction

    // one operation; intr pulses a second issue while busy
    task automatic op(input iopta_req_type q, input bit intr);
        logic [511:0] exp;
        logic [2:0]   es;
        int           n;
        @(posedge ref_clk_i);
        load <= 1'b1;
        @(posedge ref_clk_i);
        load <= 1'b0;
        issue_i <= 1'b1;
        req_i <= q;
        @(posedge ref_clk_i);
        issue_i <= 1'b0;
        exp = ref_tile(q);
        es = q.wide ? q.destination_tile_select
                    : {1'b0, q.destination_tile_select[1:0]};
        n = 0;
        while (n < 40 && done_o !== 1'b1) begin
            @(posedge ref_clk_i);
            issue_i <= intr && n == 2;
            if (intr && n == 2) req_i <= iopta_req_type'(~q);
            n++;
            #1;
        end
        `CHK("latency", q.wide ? 4 : 16, n)
        `CHK("tile", exp, res)
        `CHK("select", es, sel)
    endtask

    task s_narrow_acc;
        @(posedge ref_clk_i);
        va <= 128'h80FF_017F_8080_7F7F_0102_0304_FE80_0180;
        vb <= 128'h8080_8080_7F01_FF02_0A0B_0C0D_7F7F_7F7F;
        lt <= {16{32'h7FFF_FF00}};
        op('{OP_ACCUMULATE, 1'b0, 3'h2, 3'h2, 3'h5}, 1'b0);
        $display("test narrow accumulate done");
    endtask

    task s_narrow_sub;
        @(posedge ref_clk_i);
        lt <= {16{32'h8000_0010}};
        op('{OP_SUBTRACT, 1'b0, 3'h7, 3'h0, 3'h7}, 1'b1);
        $display("test narrow subtract done");
    endtask

    task s_wide;
        @(posedge ref_clk_i);
        va <= 128'h8000_7FFF_0001_FFFF_1234_8000_8000_0003;
        vb <= 128'h8000_8000_7FFF_FFFE_0010_8000_0200_0004;
        lt <= {8{64'h8000_0000_0000_0010}};
        op('{OP_ACCUMULATE, 1'b1, 3'h5, 3'h1, 3'h6}, 1'b0);
        op('{OP_SUBTRACT, 1'b1, 3'h7, 3'h3, 3'h4}, 1'b0);
        $display("test wide done");
    endtask

    task s_undef;
        @(posedge ref_clk_i);
        ce_i <= 1'b0;
        issue_i <= 1'b1;
        req_i <= '{OP_ACCUMULATE, 1'b1, 3'h1, 3'h1, 3'h2};
        @(posedge ref_clk_i);
        ce_i <= 1'b1;
        #1;
        `CHK("gated undef", 1'b0, u2)
        `CHK("gated busy", 1'b0, busy_o)
        @(posedge ref_clk_i);
        issue_i <= 1'b0;
        #1;
        `CHK("undef", 1'b1, u2)
        `CHK("busy2", 1'b0, b2)
        `CHK("feat2", 1'b0, f2)
        `CHK("feat", 1'b1, feat)
        `CHK("undef1", 1'b0, undefined_o)
        @(posedge ref_clk_i);
        #1;
        `CHK("undef pulse", 1'b0, u2)
        repeat (6) @(posedge ref_clk_i);
        $display("test undefined done");
    endtask

    task conclude;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            conclude;
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        s_narrow_acc;
        s_narrow_sub;
        s_wide;
        s_undef;
        conclude;
    end
endmodule
